// ### inc/rtc_timer_defs.svh
`ifndef RTC_TIMER_DEFS_SVH
`define RTC_TIMER_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_PLL_CTRL 8'h00
`define OFS_INT_CTRL 8'h04
`define OFS_MATCH 8'h08
`define OFS_FRAC 8'h0c
`define OFS_SEC 8'h10
`define OFS_MIN 8'h14
`define OFS_SIXTY_M_TALLY 8'h18
`define OFS_IRQ_STAT 8'h1c
`define OFS_IRQ_MASK 8'h20

// ----------------------------------------
// field positions
// ----------------------------------------
`define PLL_OSC_HALT 7
`define IC_RUN 0
`define IC_CNT_EN 1
`define IC_HIT 2
`define IC_SHOT 3
`define IC_TB_LO 4
`define IC_TB_HI 5
`define IRQ_HIT 0
`define IRQ_DAY 1

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define TIME_RESET 8'h00
`define MATCH_RESET 8'h00
`define XTAL_PER_FRAC 256
`define FRAC_WRAP 7'h7f
`define SEC_WRAP 6'h3b
`define MIN_WRAP 6'h3b
`define SIXTY_M_TALLY_WRAP 5'h17
`define WAKE_VECTOR 16'h0053

`endif

// ### inc/rtc_timer_pkg.sv
package rtc_timer_pkg;

  typedef enum logic [1:0] {
    TB_FRAC = 2'b00,
    TB_SEC = 2'b01,
    TB_MIN = 2'b10,
    TB_SIXTY_M_TALLY = 2'b11
  } timebase_e;

  typedef struct packed {
    logic [4:0] sixty_m_tally;
    logic [5:0] min;
    logic [5:0] sec;
    logic [6:0] frac;
  } time_s;

  typedef struct packed {
    logic shot;
    logic hit;
    logic cntEn;
    logic run;
  } ictrl_s;

endpackage : rtc_timer_pkg

// ### rtl/wakeup_interval_rtc_timer.sv
// The register addresses and the APB register port were decided locally.
`timescale 1ns/100ps
`include "rtc_timer_defs.svh"
module wakeup_interval_rtc_timer (
  // system
  input wire logic clk,
  input wire logic srst,
  input wire logic powerOnRst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // crystal and power
  input wire logic xtalClk,
  input wire logic powerDown,
  output logic oscRun,
  // core side
  output logic irq,
  output logic wake,
  output logic [15:0] wakeVector
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  rtc_timer_pkg::time_s time_reg;
  rtc_timer_pkg::ictrl_s ctrl_reg;
  logic run_reg;
  logic cntEn_reg;
  logic shot_reg;
  logic hit_reg;
  rtc_timer_pkg::timebase_e tb_reg;
  logic haltBit_reg;
  logic [7:0] match_reg;
  logic [7:0] icnt_reg;
  logic [7:0] icnt_next;
  logic [7:0] pre_reg;
  logic [1:0] irqStat_reg;
  logic [1:0] irqMask_reg;
  logic xtalMeta_reg;
  logic xtalSync_reg;
  logic xtalLast_reg;
  logic xtalEdge;
  logic fracTick;
  logic ovfFrac;
  logic ovfSec;
  logic ovfMin;
  logic ovfHour;
  logic selOvf;
  logic intervalHit;
  logic wrEn;
  logic rdSetup;
  logic mapped;

  assign wrEn = psel & penable & pwrite;
  assign rdSetup = psel & ~penable;
  assign pready = psel & penable;
  // one flop per field, so every control bit has a single writer
  assign ctrl_reg = {shot_reg, hit_reg, cntEn_reg, run_reg};

  always_comb begin
    case (paddr)
      `OFS_PLL_CTRL, `OFS_INT_CTRL, `OFS_MATCH, `OFS_FRAC, `OFS_SEC,
      `OFS_MIN, `OFS_SIXTY_M_TALLY, `OFS_IRQ_STAT, `OFS_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------
  // crystal sampling
  // ----------------------------------------
  // oscillator stops only when asked to halt in power-down
  assign oscRun = ~(haltBit_reg & powerDown);

  always_ff @(posedge clk) begin
    xtalMeta_reg <= xtalClk;
    xtalSync_reg <= xtalMeta_reg;
    xtalLast_reg <= xtalSync_reg;
  end

  // a halted oscillator gives no edges, so time stops with it
  assign xtalEdge = xtalSync_reg & ~xtalLast_reg & oscRun;

  always_ff @(posedge clk) begin
    if (srst | powerOnRst) begin
      pre_reg <= 8'h00;
    end else if (xtalEdge & ctrl_reg.run) begin
      pre_reg <= pre_reg + 8'h01;
    end
  end

  assign fracTick = xtalEdge & ctrl_reg.run & (pre_reg == 8'((`XTAL_PER_FRAC) - 1));

  // ----------------------------------------
  // time of day
  // ----------------------------------------
  assign ovfFrac = fracTick & (time_reg.frac == `FRAC_WRAP);
  assign ovfSec = ovfFrac & (time_reg.sec == `SEC_WRAP);
  assign ovfMin = ovfSec & (time_reg.min == `MIN_WRAP);
  assign ovfHour = ovfMin & (time_reg.sixty_m_tally == `SIXTY_M_TALLY_WRAP);

  // day count left to software; sixty_m_tally wrap is offered as an event only
  always_ff @(posedge clk) begin
    if (powerOnRst | (srst & ~ctrl_reg.run)) begin
      time_reg <= '0;
    end else if (srst) begin
      time_reg <= time_reg;
    end else if (wrEn & ~ctrl_reg.run) begin
      case (paddr)
        `OFS_FRAC: time_reg.frac <= pwdata[6:0];
        `OFS_SEC: time_reg.sec <= pwdata[5:0];
        `OFS_MIN: time_reg.min <= pwdata[5:0];
        `OFS_SIXTY_M_TALLY: time_reg.sixty_m_tally <= pwdata[4:0];
        default: time_reg <= time_reg;
      endcase
    end else if (fracTick) begin
      time_reg.frac <= ovfFrac ? 7'h00 : time_reg.frac + 7'h01;
      if (ovfFrac) begin
        time_reg.sec <= ovfSec ? 6'h00 : time_reg.sec + 6'h01;
      end
      if (ovfSec) begin
        time_reg.min <= ovfMin ? 6'h00 : time_reg.min + 6'h01;
      end
      if (ovfMin) begin
        time_reg.sixty_m_tally <= ovfHour ? 5'h00 : time_reg.sixty_m_tally + 5'h01;
      end
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (powerOnRst | (srst & ~ctrl_reg.run)) begin
      run_reg <= 1'b0;
    end else if (srst) begin
      run_reg <= 1'b1;
    end else if (wrEn & (paddr == `OFS_INT_CTRL)) begin
      run_reg <= pwdata[`IC_RUN];
    end
  end

  always_ff @(posedge clk) begin
    if (srst | powerOnRst) begin
      cntEn_reg <= 1'b0;
      shot_reg <= 1'b0;
      tb_reg <= rtc_timer_pkg::TB_FRAC;
      match_reg <= `MATCH_RESET;
      haltBit_reg <= 1'b0;
    end else begin
      if (wrEn & (paddr == `OFS_INT_CTRL)) begin
        cntEn_reg <= pwdata[`IC_CNT_EN];
        shot_reg <= pwdata[`IC_SHOT];
        tb_reg <= rtc_timer_pkg::timebase_e'(pwdata[`IC_TB_HI:`IC_TB_LO]);
      end else if (intervalHit & ctrl_reg.shot) begin
        cntEn_reg <= 1'b0;
      end
      if (wrEn & (paddr == `OFS_MATCH)) begin
        match_reg <= pwdata[7:0];
      end
      if (wrEn & (paddr == `OFS_PLL_CTRL)) begin
        haltBit_reg <= pwdata[`PLL_OSC_HALT];
      end
    end
  end

  // ----------------------------------------
  // interval counter
  // ----------------------------------------
  always_comb begin
    case (tb_reg)
      rtc_timer_pkg::TB_FRAC: selOvf = fracTick;
      rtc_timer_pkg::TB_SEC: selOvf = ovfFrac;
      rtc_timer_pkg::TB_MIN: selOvf = ovfSec;
      rtc_timer_pkg::TB_SIXTY_M_TALLY: selOvf = ovfMin;
      default: selOvf = 1'b0;
    endcase
  end

  // 8-bit count at sixty_m_tally base spans up to 256 hours (match of 0)
  assign icnt_next = icnt_reg + 8'h01;
  assign intervalHit = ctrl_reg.cntEn & selOvf & (icnt_next == match_reg);

  // clears at once; the long hold software gives is a margin, not a need here
  always_ff @(posedge clk) begin
    if (srst | powerOnRst | ~ctrl_reg.cntEn) begin
      icnt_reg <= 8'h00;
    end else if (intervalHit) begin
      icnt_reg <= 8'h00;
    end else if (selOvf) begin
      icnt_reg <= icnt_next;
    end
  end

  // hit flag: set wins over a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst | powerOnRst) begin
      hit_reg <= 1'b0;
    end else if (intervalHit) begin
      hit_reg <= 1'b1;
    end else if (wrEn & (paddr == `OFS_INT_CTRL)) begin
      hit_reg <= hit_reg & pwdata[`IC_HIT];
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst | powerOnRst) begin
      irqStat_reg <= 2'b00;
      irqMask_reg <= 2'b00;
    end else begin
      if (wrEn & (paddr == `OFS_IRQ_MASK)) begin
        irqMask_reg <= pwdata[1:0];
      end
      for (int i = 0; i < 2; i++) begin
        if (wrEn & (paddr == `OFS_IRQ_STAT) & pwdata[i]) begin
          irqStat_reg[i] <= 1'b0;
        end
      end
      if (intervalHit) begin
        irqStat_reg[`IRQ_HIT] <= 1'b1;
      end
      if (ovfHour) begin
        irqStat_reg[`IRQ_DAY] <= 1'b1;
      end
    end
  end

  assign irq = |(irqStat_reg & irqMask_reg);
  assign wake = powerDown & irqStat_reg[`IRQ_HIT] & irqMask_reg[`IRQ_HIT];
  assign wakeVector = `WAKE_VECTOR;

  // ----------------------------------------
  // apb read side
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst | powerOnRst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (rdSetup) begin
      pslverr <= ~mapped;
      case (paddr)
        `OFS_PLL_CTRL: prdata <= {24'h00_0000, haltBit_reg, 7'h00};
        `OFS_INT_CTRL: prdata <= {26'h0, tb_reg, ctrl_reg.shot, ctrl_reg.hit,
                                  ctrl_reg.cntEn, ctrl_reg.run};
        `OFS_MATCH: prdata <= {24'h00_0000, match_reg};
        `OFS_FRAC: prdata <= {25'h0, time_reg.frac};
        `OFS_SEC: prdata <= {26'h0, time_reg.sec};
        `OFS_MIN: prdata <= {26'h0, time_reg.min};
        `OFS_SIXTY_M_TALLY: prdata <= {27'h0, time_reg.sixty_m_tally};
        `OFS_IRQ_STAT: prdata <= {30'h0, irqStat_reg};
        `OFS_IRQ_MASK: prdata <= {30'h0, irqMask_reg};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence shotHit;
    intervalHit && ctrl_reg.shot && !wrEn;
  endsequence

  sequence countStopped;
    !ctrl_reg.cntEn && icnt_reg == 8'h00;
  endsequence

  osc_gate_a: assert property (@(posedge clk) disable iff (srst)
    (haltBit_reg && powerDown) |-> !oscRun && !xtalEdge)
    else $error("crystal edge seen while halted in power-down");

  xtal_source_a: assert property (@(posedge clk) disable iff (srst)
    fracTick |-> $rose(xtalSync_reg) && ctrl_reg.run)
    else $error("fraction tick without crystal edge");

  time_write_a: assert property (@(posedge clk) disable iff (srst || powerOnRst)
    (wrEn && paddr == `OFS_SEC && !ctrl_reg.run) |=> time_reg.sec == $past(pwdata[5:0]))
    else $error("seconds write not taken");

  time_hold_a: assert property (@(posedge clk)
    (srst && !powerOnRst && ctrl_reg.run) |=> ctrl_reg.run && time_reg == $past(time_reg))
    else $error("running clock disturbed by reset");

  time_clear_a: assert property (@(posedge clk)
    (powerOnRst || (srst && !ctrl_reg.run)) |=> !ctrl_reg.run && time_reg == '0)
    else $error("time not cleared by reset");

  frac_wrap_a: assert property (@(posedge clk) disable iff (srst || powerOnRst)
    (ovfFrac && !ovfSec) |=> time_reg.frac == 7'h00 && time_reg.sec == $past(time_reg.sec) + 6'h01)
    else $error("fraction wrap did not carry");

  interval_step_a: assert property (@(posedge clk) disable iff (srst || powerOnRst)
    (ctrl_reg.cntEn && selOvf && !intervalHit && !wrEn) |=> icnt_reg == $past(icnt_reg) + 8'h01)
    else $error("interval counter missed an overflow");

  hit_irq_a: assert property (@(posedge clk) disable iff (srst || powerOnRst)
    (intervalHit && irqMask_reg[`IRQ_HIT] && !wrEn) |=> ctrl_reg.hit ##0 irq ##0 icnt_reg == 8'h00)
    else $error("match did not raise flag and interrupt");

  wake_a: assert property (@(posedge clk) disable iff (srst || powerOnRst)
    (intervalHit && irqMask_reg[`IRQ_HIT] && !wrEn) |=> wake == powerDown && wakeVector == 16'h0053)
    else $error("enabled hit did not wake the core");

  single_shot_a: assert property (@(posedge clk) disable iff (srst || powerOnRst)
    shotHit |=> countStopped)
    else $error("single shot did not stop the counter");

  count_clear_a: assert property (@(posedge clk) disable iff (srst || powerOnRst)
    (!ctrl_reg.cntEn && !wrEn) [*2] |-> icnt_reg == 8'h00)
    else $error("disabled interval counter not clear");

  auto_reload_a: assert property (@(posedge clk) disable iff (srst || powerOnRst)
    (intervalHit && !ctrl_reg.shot && !wrEn) |=> ctrl_reg.cntEn && icnt_reg == 8'h00)
    else $error("free running interval did not reload");

  sixty_m_tally_wrap_a: assert property (@(posedge clk) disable iff (srst || powerOnRst)
    ovfHour |=> time_reg == '0 && irqStat_reg[`IRQ_DAY])
    else $error("sixty_m_tally wrap did not clear time and flag it");

endmodule : wakeup_interval_rtc_timer

// ### tb/tb.sv
`timescale 1ns/100ps
`include "rtc_timer_defs.svh"
// ----------------------------------------
// comparison
// ----------------------------------------
`define CHECK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", what, exp, got); end end
module tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic powerOnRst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic xtalClk = 1'b0;
  logic powerDown = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic oscRun;
  logic irq;
  logic wake;
  logic [15:0] wakeVector;
  int miscompares = 0;
  int comparisons = 0;
  logic [7:0] offs [9] = '{`OFS_PLL_CTRL, `OFS_INT_CTRL, `OFS_MATCH, `OFS_FRAC, `OFS_SEC, `OFS_MIN,
    `OFS_SIXTY_M_TALLY, `OFS_IRQ_STAT, `OFS_IRQ_MASK};
  logic [31:0] maxv [4] = '{32'h7f, 32'h3b, 32'h3b, 32'h17};
  logic [31:0] rd;
  logic err;
  logic [1:0] kk;

  wakeup_interval_rtc_timer wakeup_interval_rtc_timer_i (
    .clk(clk), .srst(srst), .powerOnRst(powerOnRst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xtalClk(xtalClk), .powerDown(powerDown), .oscRun(oscRun),
    .irq(irq), .wake(wake), .wakeVector(wakeVector)
  );

  always #4 clk = ~clk;

  // crystal far faster than real so a fraction tick takes about 1024 clocks
  always begin
    repeat (2) @(posedge clk);
    xtalClk <= ~xtalClk;
  end

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic apbXfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apbXfer

  task automatic apbWrite(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apbXfer(1'b1, a, d, q, e);
  endtask : apbWrite

  task automatic chkReg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apbXfer(1'b0, a, 32'h0, q, e);
    `CHECK($sformatf("reg %h", a), exp, q)
  endtask : chkReg

  task automatic pulse(input bit por);
    if (por) powerOnRst <= 1'b1; else srst <= 1'b1;
    repeat (2) @(posedge clk);
    powerOnRst <= 1'b0;
    srst <= 1'b0;
  endtask : pulse

  task automatic conclude();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    powerOnRst <= 1'b0;
    for (int i = 0; i < 9; i++) chkReg(offs[i], 32'h0);
    apbXfer(1'b0, 8'h40, 32'h0, rd, err);
    `CHECK("slverr", 1'b1, err)
    `CHECK("unmapped", 32'h0, rd)
    apbWrite(`OFS_PLL_CTRL, 32'h80);
    chkReg(`OFS_PLL_CTRL, 32'h80);
    powerDown <= 1'b1;
    repeat (2) @(posedge clk);
    `CHECK("oscRun", 1'b0, oscRun)
    apbWrite(`OFS_PLL_CTRL, 32'h0);
    @(posedge clk);
    `CHECK("oscRun", 1'b1, oscRun)
    powerDown <= 1'b0;
    // every timebase; chain up to and including the chosen register preloaded to wrap on the next tick
    for (int k = 0; k < 4; k++) begin
      kk = k[1:0];
      apbWrite(`OFS_INT_CTRL, 32'h0);
      apbWrite(`OFS_IRQ_STAT, 32'h3);
      apbWrite(`OFS_IRQ_MASK, 32'h1);
      for (int j = 0; j < 4; j++) apbWrite(offs[3+j], (j <= k) ? maxv[j] : 32'h0);
      apbWrite(`OFS_MATCH, 32'h1);
      apbWrite(`OFS_INT_CTRL, {26'h0, kk, kk[0], 3'b011});
      for (int n = 0; n < 4000 && irq !== 1'b1; n++) @(posedge clk);
      `CHECK("irq", 1'b1, irq)
      powerDown <= 1'b1;
      repeat (2) @(posedge clk);
      `CHECK("wake", 1'b1, wake)
      `CHECK("wakeVector", 16'h0053, wakeVector)
      powerDown <= 1'b0;
      chkReg(`OFS_INT_CTRL, {26'h0, kk, kk[0], 1'b1, ~kk[0], 1'b1});
      chkReg(`OFS_IRQ_STAT, (k == 3) ? 32'h3 : 32'h1);
      for (int j = 0; j < 4; j++) chkReg(offs[3+j], (j == k + 1) ? 32'h1 : 32'h0);
      apbWrite(`OFS_IRQ_MASK, 32'h0);
      @(posedge clk);
      `CHECK("irq masked", 1'b0, irq)
    end
    apbWrite(`OFS_INT_CTRL, 32'h0);
    apbWrite(`OFS_SIXTY_M_TALLY, 32'h5);
    apbWrite(`OFS_INT_CTRL, 32'h1);
    apbWrite(`OFS_SIXTY_M_TALLY, 32'h9);
    chkReg(`OFS_SIXTY_M_TALLY, 32'h5);
    pulse(1'b0);
    chkReg(`OFS_INT_CTRL, 32'h1);
    chkReg(`OFS_SIXTY_M_TALLY, 32'h5);
    pulse(1'b1);
    chkReg(`OFS_INT_CTRL, 32'h0);
    chkReg(`OFS_SIXTY_M_TALLY, 32'h0);
    apbWrite(`OFS_SIXTY_M_TALLY, 32'h3);
    pulse(1'b0);
    chkReg(`OFS_SIXTY_M_TALLY, 32'h0);
    conclude();
  end

  // whole run is near 4400 clocks; about nine times that means a hang
  initial begin
    #(8 * 40000);
    miscompares++;
    conclude();
  end
endmodule : tb
